//--- inc/fsr_defs.svh
// Opcodes, bit positions, masks and counts of the flash status register logic
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

`define FSR_OP_READ_ONE 8'h05
`define FSR_OP_READ_TWO 8'h35
`define FSR_OP_WRITE_STATUS 8'h01
`define FSR_OP_WRITE_ENABLE 8'h06
`define FSR_OP_WRITE_DISABLE 8'h04
`define FSR_OP_PAGE_PROGRAM 8'h02
`define FSR_OP_ERASE_4K 8'h20
`define FSR_OP_ERASE_32K 8'h52
`define FSR_OP_ERASE_64K 8'hD8
`define FSR_OP_CHIP_ERASE_A 8'hC7
`define FSR_OP_CHIP_ERASE_B 8'h60
`define FSR_OP_SEC_PROGRAM 8'h42
`define FSR_OP_SEC_ERASE 8'h44

`define FSR_B1_WRITE_MASK 8'hFC
`define FSR_B2_WRITE_MASK 8'h7B
`define FSR_B1_RESET 6'h00
`define FSR_B2_RESET 8'h00
`define FSR_B2_PROT_HIGH 0
`define FSR_B2_QUAD 1
`define FSR_B2_LOCK_LO 3
`define FSR_B2_LOCK_HI 5
`define FSR_B2_CMP 6
`define FSR_B1_FIELD_LO 2
`define FSR_B1_PROT_LOW 5

`define FSR_IDX_OPCODE 4'h0
`define FSR_IDX_DATA1 4'h1
`define FSR_IDX_DATA2 4'h2
`define FSR_CNT_OPCODE 4'h1
`define FSR_CNT_ONE_DATA 4'h2
`define FSR_CNT_TWO_DATA 4'h3
`define FSR_CNT_ADDRESS 4'h4
`define FSR_CNT_MAX 4'hF
`define FSR_BIT_FIRST 3'h7
`define FSR_BIT_ZERO 3'h0
`define FSR_PAGE_FIRST 8'h01
`define FSR_PAGE_LAST 8'h03

`endif

//--- inc/fsr_pkg.sv
// Types and shared decode functions of the flash status register logic
`include "fsr_defs.svh"

package fsr_pkg;

    typedef enum logic [3:0] {
        FSR_CMD_NONE = 4'b0000,
        FSR_CMD_READ_ONE = 4'b0001,
        FSR_CMD_READ_TWO = 4'b0010,
        FSR_CMD_WRITE_STATUS = 4'b0011,
        FSR_CMD_WRITE_ENABLE = 4'b0100,
        FSR_CMD_WRITE_DISABLE = 4'b0101,
        FSR_CMD_ARRAY = 4'b0110,
        FSR_CMD_CHIP = 4'b0111,
        FSR_CMD_SECPAGE = 4'b1000,
        FSR_CMD_OTHER = 4'b1001
    } fsr_cmd_e;

    function automatic fsr_cmd_e fsr_decode(input logic [7:0] op);
        case (op)
            `FSR_OP_READ_ONE: fsr_decode = FSR_CMD_READ_ONE;
            `FSR_OP_READ_TWO: fsr_decode = FSR_CMD_READ_TWO;
            `FSR_OP_WRITE_STATUS: fsr_decode = FSR_CMD_WRITE_STATUS;
            `FSR_OP_WRITE_ENABLE: fsr_decode = FSR_CMD_WRITE_ENABLE;
            `FSR_OP_WRITE_DISABLE: fsr_decode = FSR_CMD_WRITE_DISABLE;
            `FSR_OP_PAGE_PROGRAM, `FSR_OP_ERASE_4K, `FSR_OP_ERASE_32K,
            `FSR_OP_ERASE_64K: fsr_decode = FSR_CMD_ARRAY;
            `FSR_OP_CHIP_ERASE_A, `FSR_OP_CHIP_ERASE_B: fsr_decode = FSR_CMD_CHIP;
            `FSR_OP_SEC_PROGRAM, `FSR_OP_SEC_ERASE: fsr_decode = FSR_CMD_SECPAGE;
            default: fsr_decode = FSR_CMD_OTHER;
        endcase
    endfunction

    // Protect pair and write-protect level decide whether status may change
    function automatic logic fsr_status_writable(input logic prot_high, input logic prot_low,
                                                 input logic wp_high);
        fsr_status_writable = !prot_high && (!prot_low || wp_high);
    endfunction

endpackage

//--- logic/fsr_spi_frame.sv
// Serial frame engine: pin synchronisers, byte receiver, status byte shifter
`include "fsr_defs.svh"
module fsr_spi_frame
    import fsr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic tx_enable,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic frame_start,
    output logic frame_end,
    output logic [2:0] bit_count,
    output logic so_out,
    output logic so_oe
);
    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] si_sync;
    logic sclk_prev;
    logic cs_prev;
    logic [6:0] rx_shift;
    logic [2:0] tx_index;
    logic [7:0] tx_snap;

    wire sclk_rise = sclk_sync[1] & ~sclk_prev;
    wire sclk_fall = ~sclk_sync[1] & sclk_prev;
    wire selected = ~cs_sync[1];
    wire byte_done = sclk_rise && selected && (bit_count == `FSR_BIT_FIRST);
    wire first_bit = (tx_index == `FSR_BIT_FIRST);
    wire tx_bit = first_bit ? tx_byte[`FSR_BIT_FIRST] : tx_snap[tx_index];

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            si_sync <= 2'h0;
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end
        else
        begin
            sclk_sync <= {sclk_sync[0], sclk};
            cs_sync <= {cs_sync[0], cs_n};
            si_sync <= {si_sync[0], si};
            sclk_prev <= sclk_sync[1];
            cs_prev <= cs_sync[1];
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            frame_start <= 1'b0;
            frame_end <= 1'b0;
            bit_count <= 3'h0;
            rx_shift <= 7'h00;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
        end
        else
        begin
            frame_start <= cs_prev & ~cs_sync[1];
            frame_end <= ~cs_prev & cs_sync[1];
            rx_valid <= byte_done;
            if (frame_start)
                bit_count <= 3'h0;
            else if (sclk_rise && selected)
                bit_count <= bit_count + 3'h1;
            if (sclk_rise && selected)
                rx_shift <= {rx_shift[5:0], si_sync[1]};
            if (byte_done)
                rx_byte <= {rx_shift, si_sync[1]};
        end
    end

    // Whole byte is snapped at its MSB so one repetition is never torn
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            tx_index <= `FSR_BIT_FIRST;
            tx_snap <= 8'h00;
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end
        else if (!selected)
        begin
            tx_index <= `FSR_BIT_FIRST; // [R05]
            so_oe <= 1'b0; // [R05]
        end
        else if (sclk_fall && tx_enable)
        begin
            so_out <= tx_bit; // [R22]
            so_oe <= 1'b1;
            tx_index <= tx_index - 3'h1; // [R04]
            if (first_bit)
                tx_snap <= tx_byte; // [R04]
        end
    end
endmodule

//--- logic/fsr_status_regs.sv
// Status register bank of a serial flash: reads, writes, protection, write latch
`include "fsr_defs.svh"
// Functional notes
// [R01] Status reads work even while busy
// [R02] Opcode 05h streams first status byte
// [R03] Opcode 35h streams second status byte
// [R04] After bit 0 restart at bit 7, fresh
// [R05] Chip select high ends read, output released
// [R06] Byte one: protect, size, end, level, latch, busy
// [R07] Writes touch only byte one bits 7..2
// [R08] Byte two: complement, locks, quad, protect high
// [R09] Byte two bits 7, 2 read zero
// [R10] Protect pair and pin gate status writes
// [R11] Pattern 10 locks until power cycle; 11 forever
// [R12] Power cycle turns pattern 10 into 00
// [R13] Protection fields exported to array protection
// [R14] Latch clear rejects program, erase, status write
// [R15] Latch reads zero after reset
// [R16] Latch clears on write disable, write ops
// [R17] Partial or unknown opcode keeps latch
// [R18] Busy reads one during internal operations
// [R19] Host polls until busy drops
// [R20] Set lock bit refuses page program/erase
// [R21] Quad enable turns hold, protect pins bidirectional
// [R22] Bits MSB first, change on falling clock
module fsr_status_regs
    import fsr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic power_cycle,
    input wire logic array_busy,
    output logic so_out,
    output logic so_oe,
    output logic op_start,
    output logic [7:0] op_code,
    output logic [7:0] status_byte_one,
    output logic [7:0] status_byte_two,
    output logic [5:0] protect_fields,
    output logic [2:0] page_locks,
    output logic quad_pins_bidir
);
    logic [1:0] wp_sync;
    fsr_cmd_e cmd;
    logic [3:0] byte_count;
    logic [7:0] opcode_held;
    logic [7:0] data_one;
    logic [7:0] data_two;
    logic [5:0] byte_one_fields;
    logic [7:0] byte_two_store;
    logic write_enable_latch;
    logic busy_flag;
    logic tx_enable;
    logic frame_so_out;
    logic frame_so_oe;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic frame_start;
    logic frame_end;
    logic [2:0] bit_count;

    fsr_spi_frame u_frame (
        .clock(clock),
        .reset(reset),
        .sclk(sclk),
        .cs_n(cs_n),
        .si(si),
        .tx_enable(tx_enable),
        .tx_byte((cmd == FSR_CMD_READ_TWO) ? status_byte_two : status_byte_one),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .frame_start(frame_start),
        .frame_end(frame_end),
        .bit_count(bit_count),
        .so_out(frame_so_out),
        .so_oe(frame_so_oe)
    );

    // Field views of the stored bytes
    wire prot_low = byte_one_fields[`FSR_B1_PROT_LOW];
    wire prot_high = byte_two_store[`FSR_B2_PROT_HIGH];
    wire quad_enable = byte_two_store[`FSR_B2_QUAD];
    wire [2:0] lock_bits = byte_two_store[`FSR_B2_LOCK_HI:`FSR_B2_LOCK_LO];

    // In quad mode the protect pin carries data, so it no longer locks status
    wire wp_high = wp_sync[1] | quad_enable; // [R21]

    wire aligned = (bit_count == `FSR_BIT_ZERO);
    wire just_opcode = aligned && (byte_count == `FSR_CNT_OPCODE);
    wire status_len_ok = aligned && ((byte_count == `FSR_CNT_ONE_DATA) ||
                                     (byte_count == `FSR_CNT_TWO_DATA));
    wire addr_len_ok = aligned && (byte_count >= `FSR_CNT_ADDRESS);
    wire write_type = (cmd == FSR_CMD_WRITE_STATUS) || (cmd == FSR_CMD_ARRAY) ||
                      (cmd == FSR_CMD_CHIP) || (cmd == FSR_CMD_SECPAGE);

    // Lock check on the page byte of a security page address
    wire page_in_range = (data_two >= `FSR_PAGE_FIRST) && (data_two <= `FSR_PAGE_LAST);
    wire [1:0] page_sel = data_two[1:0] - 2'h1;
    wire page_locked = page_in_range && lock_bits[page_sel]; // [R20]

    wire status_write_ok = frame_end && (cmd == FSR_CMD_WRITE_STATUS) &&
                           write_enable_latch && !busy_flag && status_len_ok &&
                           fsr_status_writable(prot_high, prot_low, wp_high); // [R10] [R11] [R14]
    wire array_go = (cmd == FSR_CMD_ARRAY) ? addr_len_ok :
                    (cmd == FSR_CMD_CHIP) ? just_opcode :
                    (cmd == FSR_CMD_SECPAGE) ? (addr_len_ok && page_in_range && !page_locked) :
                    1'b0; // [R20]
    wire next_op_start = frame_end && write_enable_latch && !busy_flag && array_go; // [R14]

    // Byte two write keeps reserved bits zero and lock bits one-time set
    wire [7:0] byte_two_written = (data_two & `FSR_B2_WRITE_MASK) |
                                  {2'b00, lock_bits, 3'b000}; // [R09]

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            wp_sync <= 2'h0;
        else
            wp_sync <= {wp_sync[0], wp_n};
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            busy_flag <= 1'b0;
        else
            busy_flag <= array_busy; // [R18]
    end

    // Command tracking per frame
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cmd <= FSR_CMD_NONE;
            byte_count <= 4'h0;
            opcode_held <= 8'h00;
            data_one <= 8'h00;
            data_two <= 8'h00;
        end
        else if (frame_start)
        begin
            cmd <= FSR_CMD_NONE;
            byte_count <= 4'h0;
        end
        else if (rx_valid)
        begin
            if (byte_count != `FSR_CNT_MAX)
                byte_count <= byte_count + 4'h1;
            if (byte_count == `FSR_IDX_OPCODE)
            begin
                cmd <= fsr_decode(rx_byte); // [R02] [R03]
                opcode_held <= rx_byte;
            end
            if (byte_count == `FSR_IDX_DATA1)
                data_one <= rx_byte;
            if (byte_count == `FSR_IDX_DATA2)
                data_two <= rx_byte;
        end
    end

    // Status reads are served regardless of busy
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            tx_enable <= 1'b0;
        else
            tx_enable <= (cmd == FSR_CMD_READ_ONE) || (cmd == FSR_CMD_READ_TWO); // [R01] [R02] [R03]
    end

    // Write enable latch
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            write_enable_latch <= 1'b0; // [R15]
        else if (power_cycle)
            write_enable_latch <= 1'b0; // [R15]
        else if (frame_end)
        begin
            if (cmd == FSR_CMD_WRITE_ENABLE && just_opcode && !busy_flag)
                write_enable_latch <= 1'b1;
            else if (cmd == FSR_CMD_WRITE_DISABLE && just_opcode)
                write_enable_latch <= 1'b0; // [R16]
            else if (write_type)
                write_enable_latch <= 1'b0; // [R16] [R17]
        end
    end

    // Writable status fields
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            byte_one_fields <= `FSR_B1_RESET;
            byte_two_store <= `FSR_B2_RESET; // [R08]
        end
        else if (power_cycle)
        begin
            if (prot_high && !prot_low)
            begin
                byte_two_store[`FSR_B2_PROT_HIGH] <= 1'b0; // [R12]
            end
        end
        else if (status_write_ok)
        begin
            byte_one_fields <= data_one[7:`FSR_B1_FIELD_LO]; // [R07]
            if (byte_count == `FSR_CNT_TWO_DATA)
                byte_two_store <= byte_two_written; // [R09]
        end
    end

    // Array operation launch toward the program/erase engine
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            op_start <= 1'b0;
            op_code <= 8'h00;
        end
        else
        begin
            op_start <= next_op_start; // [R14]
            if (next_op_start)
                op_code <= opcode_held;
        end
    end

    // Registered views; reads see them one clock behind the fields
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            status_byte_one <= 8'h00;
            status_byte_two <= 8'h00;
            protect_fields <= 6'h00;
            page_locks <= 3'h0;
            quad_pins_bidir <= 1'b0;
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end
        else
        begin
            status_byte_one <= {byte_one_fields, write_enable_latch, busy_flag}; // [R06]
            status_byte_two <= byte_two_store & `FSR_B2_WRITE_MASK; // [R08] [R09]
            protect_fields <= {byte_two_store[`FSR_B2_CMP], byte_one_fields[4:0]}; // [R13]
            page_locks <= lock_bits; // [R20]
            quad_pins_bidir <= quad_enable; // [R21]
            so_out <= frame_so_out; // [R22]
            so_oe <= frame_so_oe; // [R05]
        end
    end
endmodule

//--- verif/fsr_chk.sv
// Port-level assertion checker of the flash status register logic
module fsr_chk
(
    input wire logic clock,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic power_cycle,
    input wire logic array_busy,
    input wire logic so_oe,
    input wire logic op_start,
    input wire logic [7:0] status_byte_one,
    input wire logic [7:0] status_byte_two,
    input wire logic [5:0] protect_fields,
    input wire logic [2:0] page_locks,
    input wire logic quad_pins_bidir
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // Output release lags the select pin by the two synchroniser stages plus two output registers, four clocks
    sequence cs_idle;
        cs_n [*8];
    endsequence
    sequence byte_one_written;
        $changed(status_byte_one[7:2]);
    endsequence

    // Busy passes a flag stage and the registered view, two clocks in all
    busy_follow_a: assert property (status_byte_one[0] == $past(array_busy, 2))
        else $error("busy flag does not follow engine");
    reserved_zero_a: assert property (!status_byte_two[7] && !status_byte_two[2])
        else $error("reserved bit set");
    fields_mirror_a: assert property (protect_fields == {status_byte_two[6], status_byte_one[6:2]})
        else $error("protection fields differ from status");
    locks_mirror_a: assert property (page_locks == status_byte_two[5:3])
        else $error("page locks differ from status");
    locks_sticky_a: assert property (($past(page_locks) & ~page_locks) == 3'h0)
        else $error("page lock cleared");
    quad_mirror_a: assert property (quad_pins_bidir == status_byte_two[1])
        else $error("quad output differs from status");
    oe_release_a: assert property (cs_idle |-> !so_oe)
        else $error("output driven without select");
    otp_hold_a: assert property (status_byte_two[0] && status_byte_one[7]
        |=> $stable(status_byte_one[7:2]) && $stable(status_byte_two))
        else $error("permanently protected status changed");
    // The view lags the power event by two clocks, so both cycles are excused
    lockdown_hold_a: assert property (status_byte_two[0] && !status_byte_one[7] && !power_cycle
        && !$past(power_cycle)
        |=> $stable(status_byte_one[7:2]) && $stable(status_byte_two))
        else $error("locked-down status changed");
    power_unlock_a: assert property (power_cycle && status_byte_two[0] && !status_byte_one[7]
        |-> ##[1:2] !status_byte_two[0] && !status_byte_one[1])
        else $error("power cycle kept lock-down");
    write_gate_a: assert property (byte_one_written
        |-> $past(status_byte_one[1]) && !$past(status_byte_two[0]))
        else $error("status changed without permission");
    start_clear_a: assert property (op_start |-> ##[0:4] !status_byte_one[1])
        else $error("latch kept after operation start");
endmodule

//--- verif/fsr_host.sv
// SPI host model: mode 0 serial clock, select and data, samples the output
module fsr_host
(
    input wire logic clock,
    input wire logic so_out,
    input wire logic so_oe,
    output logic sclk,
    output logic cs_n,
    output logic si
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_so = 1'b0;
    logic line_so;
    // A released output floats: show the inverse of the last driven level
    assign line_so = so_oe ? so_out : ~last_so;
    always @(posedge clock)
        if (so_oe)
            last_so <= so_out;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Six clocks per phase keeps each phase longer than the synchronisers
    task automatic bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--)
        begin
            si <= tx[i];
            repeat (6) @(posedge clock);
            rx[i] = line_so;
            sclk <= 1'b1;
            repeat (6) @(posedge clock);
            sclk <= 1'b0;
        end
    endtask
    task automatic open_frame();
        @(posedge clock);
        cs_n <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    task automatic close_frame();
        repeat (6) @(posedge clock);
        cs_n <= 1'b1;
        repeat (10) @(posedge clock);
    endtask
endmodule

//--- verif/tb_flash_status_register_logic.sv
// Self-checking bench of the flash status register logic
module tb_flash_status_register_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, reset = 1, wp_n = 1, power_cycle = 0, array_busy = 0;
    logic sclk, cs_n, si, so_out, so_oe, op_start, quad_pins_bidir;
    logic [7:0] op_code, status_byte_one, status_byte_two, v;
    logic [5:0] protect_fields;
    logic [2:0] page_locks;
    int bad_count = 0, checks_done = 0, cycles = 0, starts = 0;

    fsr_status_regs u_fsr_status_regs (.clock(clock), .reset(reset), .sclk(sclk),
        .cs_n(cs_n), .si(si), .wp_n(wp_n), .power_cycle(power_cycle),
        .array_busy(array_busy), .so_out(so_out), .so_oe(so_oe), .op_start(op_start),
        .op_code(op_code), .status_byte_one(status_byte_one),
        .status_byte_two(status_byte_two), .protect_fields(protect_fields),
        .page_locks(page_locks), .quad_pins_bidir(quad_pins_bidir));
    fsr_host u_fsr_host (.clock(clock), .so_out(so_out), .so_oe(so_oe), .sclk(sclk),
        .cs_n(cs_n), .si(si));

    initial
        forever #12.5 clock = ~clock;

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmd(input int n, input logic [31:0] d);
        logic [7:0] r;
        u_fsr_host.open_frame();
        for (int i = 0; i < n; i++)
            u_fsr_host.bits(8, d[31 - 8 * i -: 8], r);
        u_fsr_host.close_frame();
    endtask
    task automatic wr(input int n, input logic [31:0] d);
        cmd(1, 32'h06000000);
        cmd(n, d);
    endtask
    task automatic expect_regs(input logic [7:0] e1, input logic [7:0] e2);
        u_fsr_host.open_frame();
        u_fsr_host.bits(8, 8'h05, v);
        u_fsr_host.bits(8, 8'hFF, v);
        u_fsr_host.close_frame();
        check(v, e1);
        check(status_byte_one, e1);
        u_fsr_host.open_frame();
        u_fsr_host.bits(8, 8'h35, v);
        u_fsr_host.bits(8, 8'hFF, v);
        u_fsr_host.close_frame();
        check(v, e2);
        check(status_byte_two, e2);
    endtask
    task automatic pulse_power();
        power_cycle <= 1'b1;
        @(posedge clock);
        power_cycle <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (op_start === 1'b1)
            starts <= starts + 1;
        if (cycles == 60000)
        begin
            bad_count++;
            summarize();
        end
    end

    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(posedge clock);
        expect_regs(8'h00, 8'h00);
        cmd(2, 32'h011C0000);
        expect_regs(8'h00, 8'h00);
        cmd(1, 32'h06000000);
        expect_regs(8'h02, 8'h00);
        u_fsr_host.open_frame();
        u_fsr_host.bits(4, 8'h01, v);
        u_fsr_host.close_frame();
        cmd(1, 32'hAB000000);
        expect_regs(8'h02, 8'h00);
        cmd(1, 32'h04000000);
        expect_regs(8'h00, 8'h00);
        wr(2, 32'h01FF0000);
        expect_regs(8'hFC, 8'h00);
        check({2'h0, protect_fields}, 8'h1F);
        wp_n <= 1'b0;
        wr(2, 32'h01000000);
        expect_regs(8'hFC, 8'h00);
        wp_n <= 1'b1;
        wr(2, 32'h01000000);
        expect_regs(8'h00, 8'h00);
        cmd(1, 32'h06000000);
        array_busy <= 1'b1;
        fork
            begin
                repeat (250) @(posedge clock);
                array_busy <= 1'b0;
            end
        join_none
        u_fsr_host.open_frame();
        u_fsr_host.bits(8, 8'h05, v);
        u_fsr_host.bits(8, 8'hFF, v);
        check(v, 8'h03);
        for (int i = 0; i < 4 && v !== 8'h02; i++)
            u_fsr_host.bits(8, 8'hFF, v);
        check(v, 8'h02);
        u_fsr_host.bits(3, 8'hFF, v);
        u_fsr_host.close_frame();
        check({7'h00, so_oe}, 8'h00);
        cmd(1, 32'h04000000);
        cmd(4, 32'h42000200);
        check(starts[7:0], 8'h00);
        wr(4, 32'h42000100);
        check(op_code, 8'h42);
        wr(3, 32'h01000800);
        expect_regs(8'h00, 8'h08);
        check({5'h00, page_locks}, 8'h01);
        wr(4, 32'h42000100);
        wr(4, 32'h44000200);
        check(starts[7:0], 8'h02);
        check(op_code, 8'h44);
        expect_regs(8'h00, 8'h08);
        wr(3, 32'h01800A00);
        expect_regs(8'h80, 8'h0A);
        check({7'h00, quad_pins_bidir}, 8'h01);
        wp_n <= 1'b0;
        wr(3, 32'h01000800);
        expect_regs(8'h00, 8'h08);
        wp_n <= 1'b1;
        wr(3, 32'h01000900);
        wr(3, 32'h011C0900);
        expect_regs(8'h00, 8'h09);
        pulse_power();
        expect_regs(8'h00, 8'h08);
        wr(3, 32'h01800900);
        pulse_power();
        wr(3, 32'h01000800);
        expect_regs(8'h80, 8'h09);
        summarize();
    end
endmodule

bind fsr_status_regs fsr_chk u_fsr_chk (.clock(clock), .reset(reset), .cs_n(cs_n),
    .power_cycle(power_cycle), .array_busy(array_busy), .so_oe(so_oe),
    .op_start(op_start), .status_byte_one(status_byte_one),
    .status_byte_two(status_byte_two), .protect_fields(protect_fields),
    .page_locks(page_locks), .quad_pins_bidir(quad_pins_bidir));
